/* File: inc/ssport_defines.svh */
// ssport_defines.svh: offsets-free constants for the sync serial port pins
// assumes inclusion by bare name from the design files
`ifndef SSPORT_DEFINES_SVH
`define SSPORT_DEFINES_SVH
`define SSP_WORD_BITS    24
`define SSP_PIN_COUNT    6
`define SSP_BIT_AUX0     0
`define SSP_BIT_AUX1     1
`define SSP_BIT_AUX2     2
`define SSP_BIT_SCK      3
`define SSP_BIT_RXD      4
`define SSP_BIT_TXD      5
`define SSP_RST_FUNC     6'h00
`define SSP_RST_DIR      6'h00
`endif

/* File: inc/ssport_pkg.sv */
// ssport_pkg.sv: types shared by the sync serial port pin logic
// assumes ssport_defines.svh sits on the include path
package ssport_pkg;
   typedef enum logic [1:0] {
      SSP_IDLE  = 2'b00,
      SSP_SHIFT = 2'b01,
      SSP_LOAD  = 2'b11
   } ssp_state_type;
endpackage : ssport_pkg

/* File: hw/ssp_buf2.sv */
// ssp_buf2.sv: two-entry valid/ready buffer
// assumes a single clock domain
`timescale 1ns/10ps
module ssp_buf2 #(
   parameter int WIDTH = 24
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   // filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   initial begin
      if (WIDTH < 1) $error("ssp_buf2: WIDTH must be positive");
   end
   logic [WIDTH-1:0] mem_q [2];
   logic [WIDTH-1:0] mem_d [2];
   logic             wr_q, wr_d, rd_q, rd_d;
   logic [1:0]       cnt_q, cnt_d;
   logic             push, pop;
   always_comb begin
      push   = inValid && (cnt_q != 2'd2);
      pop    = outReady && (cnt_q != 2'd0);
      mem_d  = mem_q;
      wr_d   = wr_q;
      rd_d   = rd_q;
      cnt_d  = cnt_q;
      if (push) begin
         mem_d[wr_q] = inData;
         wr_d        = ~wr_q;
      end
      if (pop) begin
         rd_d = ~rd_q;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 2'd1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'd1;
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         cnt_q    <= 2'd0;
      end else begin
         mem_q <= mem_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end
   assign inReady  = (cnt_q != 2'd2);
   assign outValid = (cnt_q != 2'd0);
   assign outData  = mem_q[rd_q];
endmodule : ssp_buf2

/* File: hw/ssp_port.sv */
// ssp_port.sv: pin multiplexing and shifting of the sync serial port
// assumes pin inputs are asynchronous; the bit clock is sampled by core_clk
`timescale 1ns/10ps
`include "ssport_defines.svh"
module ssp_port
   import ssport_pkg::*;
#(
   parameter int WORD_BITS = `SSP_WORD_BITS,
   parameter int CLK_DIV   = 4
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 arst_n,
   // configuration
   input  wire logic [5:0]           funcSel,
   input  wire logic [5:0]           gpioDir,
   input  wire logic [5:0]           gpioOut,
   input  wire logic                 asyncMode,
   input  wire logic                 clkOutMode,
   input  wire logic                 fsOutMode,
   input  wire logic [1:0]           flagOut,
   // transmit words in
   input  wire logic                 txValid,
   output logic                      txReady,
   input  wire logic [WORD_BITS-1:0] txWord,
   // receive words out
   output logic                      rxValid,
   input  wire logic                 rxReady,
   output logic [WORD_BITS-1:0]      rxWord,
   // status
   output logic [5:0]                gpioIn,
   output logic [1:0]                flagIn,
   // pins, output enable active low
   input  wire logic [5:0]           pinIn,
   output logic [5:0]                pinOut,
   output logic [5:0]                pinOen_n
);
   initial begin
      if (WORD_BITS < 2 || WORD_BITS > 32) $error("ssp_port: bad WORD_BITS");
      if (CLK_DIV < 2 || CLK_DIV > 255) $error("ssp_port: bad CLK_DIV");
   end
   localparam int CW = $clog2(WORD_BITS + 1);

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [5:0] sync1_q, sync2_q, prev_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= pinIn;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // ----------------------------------------------------------------
   // bit clock source and edges
   // ----------------------------------------------------------------
   logic [7:0] div_q, div_d;
   logic       genClk_q, genClk_d;
   logic       clkIsOut, rise, fall, fsIsOut;
   always_comb begin
      div_d    = div_q;
      genClk_d = genClk_q;
      if (div_q == 8'(CLK_DIV / 2 - 1)) begin
         div_d    = 8'h00;
         genClk_d = ~genClk_q;
      end else begin
         div_d = div_q + 8'h01;
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_q    <= 8'h00;
         genClk_q <= 1'b0;
      end else begin
         div_q    <= div_d;
         genClk_q <= genClk_d;
      end
   end
   // clock out mode uses the divider; otherwise async mode takes the clock on aux zero, else on the serial clock pin
   always_comb begin
      clkIsOut = clkOutMode;
      fsIsOut  = fsOutMode;
      if (clkIsOut) begin
         rise = (div_q == 8'(CLK_DIV / 2 - 1)) && !genClk_q;
         fall = (div_q == 8'(CLK_DIV / 2 - 1)) && genClk_q;
      end else if (asyncMode) begin
         rise = sync2_q[`SSP_BIT_AUX0] & ~prev_q[`SSP_BIT_AUX0];
         fall = ~sync2_q[`SSP_BIT_AUX0] & prev_q[`SSP_BIT_AUX0];
      end else begin
         rise = sync2_q[`SSP_BIT_SCK] & ~prev_q[`SSP_BIT_SCK];
         fall = ~sync2_q[`SSP_BIT_SCK] & prev_q[`SSP_BIT_SCK];
      end
   end

   // ----------------------------------------------------------------
   // shift engine
   // ----------------------------------------------------------------
   ssp_state_type         st_q, st_d;
   logic [WORD_BITS-1:0]  txSh_q, txSh_d, rxSh_q, rxSh_d;
   logic [CW-1:0]         cnt_q, cnt_d;
   logic                  bufValid, bufReady, pushV;
   logic [WORD_BITS-1:0]  pushW;
   logic                  fsPulse_q, fsPulse_d;
   always_comb begin
      st_d      = st_q;
      txSh_d    = txSh_q;
      rxSh_d    = rxSh_q;
      cnt_d     = cnt_q;
      pushV     = 1'b0;
      pushW     = rxSh_q;
      fsPulse_d = fsPulse_q;
      unique case (st_q)
         SSP_IDLE: begin
            if (txValid && funcSel[`SSP_BIT_TXD] && rise) begin
               txSh_d    = txWord;
               cnt_d     = CW'(WORD_BITS);
               fsPulse_d = 1'b1;
               st_d      = SSP_SHIFT;
            end
         end
         SSP_SHIFT: begin
            if (fall) begin
               rxSh_d = {rxSh_q[WORD_BITS-2:0], sync2_q[`SSP_BIT_RXD]};
               cnt_d  = cnt_q - CW'(1);
               fsPulse_d = 1'b0;
               if (cnt_q == CW'(1)) begin
                  st_d = SSP_LOAD;
               end
            end
            if (rise && cnt_q != CW'(WORD_BITS)) begin
               txSh_d = {txSh_q[WORD_BITS-2:0], 1'b0};
            end
         end
         SSP_LOAD: begin
            pushV = 1'b1;
            if (bufReady) begin
               st_d = SSP_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q      <= SSP_IDLE;
         txSh_q    <= '0;
         rxSh_q    <= '0;
         cnt_q     <= '0;
         fsPulse_q <= 1'b0;
      end else begin
         st_q      <= st_d;
         txSh_q    <= txSh_d;
         rxSh_q    <= rxSh_d;
         cnt_q     <= cnt_d;
         fsPulse_q <= fsPulse_d;
      end
   end

   ssp_buf2 #(.WIDTH(WORD_BITS)) u_rxbuf (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .inValid  (pushV),
      .inReady  (bufReady),
      .inData   (pushW),
      .outValid (bufValid),
      .outReady (rxReady),
      .outData  (rxWord)
   );
   assign rxValid = bufValid;

   // ----------------------------------------------------------------
   // pin multiplexing; disabled functions fall back to gpio
   // ----------------------------------------------------------------
   logic [5:0] out_d, oen_d, out_q, oen_q, gin_q;
   logic [1:0] flg_q;
   logic       txRdy_q;
   always_comb begin
      out_d = gpioOut;
      oen_d = ~gpioDir;
      if (funcSel[`SSP_BIT_AUX0]) begin
         if (asyncMode) begin
            out_d[`SSP_BIT_AUX0] = genClk_q;
            oen_d[`SSP_BIT_AUX0] = ~clkIsOut;
         end else begin
            out_d[`SSP_BIT_AUX0] = flagOut[0];
            oen_d[`SSP_BIT_AUX0] = ~gpioDir[`SSP_BIT_AUX0];
         end
      end
      if (funcSel[`SSP_BIT_AUX1]) begin
         if (asyncMode) begin
            out_d[`SSP_BIT_AUX1] = fsPulse_q;
            oen_d[`SSP_BIT_AUX1] = ~fsIsOut;
         end else begin
            out_d[`SSP_BIT_AUX1] = flagOut[1];
            oen_d[`SSP_BIT_AUX1] = ~gpioDir[`SSP_BIT_AUX1];
         end
      end
      if (funcSel[`SSP_BIT_AUX2]) begin
         out_d[`SSP_BIT_AUX2] = fsPulse_q;
         oen_d[`SSP_BIT_AUX2] = ~fsIsOut;
      end
      if (funcSel[`SSP_BIT_SCK]) begin
         out_d[`SSP_BIT_SCK] = genClk_q;
         oen_d[`SSP_BIT_SCK] = ~(clkIsOut && !asyncMode);
      end
      if (funcSel[`SSP_BIT_RXD]) begin
         out_d[`SSP_BIT_RXD] = 1'b0;
         oen_d[`SSP_BIT_RXD] = 1'b1;
      end
      if (funcSel[`SSP_BIT_TXD]) begin
         out_d[`SSP_BIT_TXD] = txSh_q[WORD_BITS-1];
         oen_d[`SSP_BIT_TXD] = 1'b0;
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         out_q   <= `SSP_RST_FUNC;
         oen_q   <= 6'h3F;
         gin_q   <= '0;
         flg_q   <= '0;
         txRdy_q <= 1'b0;
      end else begin
         out_q   <= out_d;
         oen_q   <= oen_d;
         gin_q   <= sync2_q;
         flg_q   <= {sync2_q[`SSP_BIT_AUX1], sync2_q[`SSP_BIT_AUX0]};
         txRdy_q <= (st_d == SSP_IDLE) && funcSel[`SSP_BIT_TXD];
      end
   end
   assign pinOut   = out_q;
   assign pinOen_n = oen_q;
   assign gpioIn   = gin_q;
   assign flagIn   = flg_q;
   assign txReady  = txRdy_q & rise;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_rst_input;
      @(posedge core_clk) $rose(arst_n) |-> pinOen_n == 6'h3F;
   endproperty
   a_rst_input: assert property (p_rst_input)
      else $error("pins not inputs after reset");
   property p_txd_drive;
      @(posedge core_clk) disable iff (!arst_n)
      funcSel[`SSP_BIT_TXD] |=> !pinOen_n[`SSP_BIT_TXD]
         || !$past(funcSel[`SSP_BIT_TXD]);
   endproperty
   a_txd_drive: assert property (p_txd_drive)
      else $error("tx data pin not driven");
   property p_gpio_fallback;
      @(posedge core_clk) disable iff (!arst_n)
      funcSel == 6'h00 |=> pinOut == $past(gpioOut) || $changed(funcSel);
   endproperty
   a_gpio_fallback: assert property (p_gpio_fallback)
      else $error("gpio value not on pins");
   property p_flag0;
      @(posedge core_clk) disable iff (!arst_n)
      funcSel[0] && !asyncMode |=> pinOut[0] == $past(flagOut[0]);
   endproperty
   a_flag0: assert property (p_flag0)
      else $error("aux zero not flag in sync mode");
   property p_flag1;
      @(posedge core_clk) disable iff (!arst_n)
      funcSel[1] && !asyncMode |=> pinOut[1] == $past(flagOut[1]);
   endproperty
   a_flag1: assert property (p_flag1)
      else $error("aux one not flag in sync mode");
   property p_fs_two;
      @(posedge core_clk) disable iff (!arst_n)
      funcSel[2] |=> pinOut[2] == $past(fsPulse_q);
   endproperty
   a_fs_two: assert property (p_fs_two)
      else $error("aux two not frame sync");
   property p_one_bit;
      @(posedge core_clk) disable iff (!arst_n)
      st_q == SSP_SHIFT && fall |=> cnt_q == $past(cnt_q) - CW'(1);
   endproperty
   a_one_bit: assert property (p_one_bit)
      else $error("bit count not one per clock");
   property p_rx_shift;
      @(posedge core_clk) disable iff (!arst_n)
      st_q == SSP_SHIFT && fall |=> rxSh_q[0] == $past(sync2_q[4]);
   endproperty
   a_rx_shift: assert property (p_rx_shift)
      else $error("rx bit not captured");
endmodule : ssp_port

/* File: test/ssp_codec_model.sv */
// ssp_codec_model.sv: behavioural serial codec on the far side of the port
// assumes the bench gates the bit clock with run; words go msb first
`timescale 1ns/10ps
module ssp_codec_model (
   // control from the bench
   input  wire logic        run,
   input  wire logic [23:0] word0,
   input  wire logic [23:0] word1,
   // serial lines
   input  wire logic        fsync,
   input  wire logic        txd,
   output logic             sck,
   output logic             rxd,
   // captured words
   output logic [23:0]      got0,
   output logic [23:0]      got1,
   output int               frames
);
   logic        busy;
   int          cnt;
   logic [23:0] shiftReg;
   logic [23:0] curWord;

   assign curWord = frames[0] ? word1 : word0;

   initial begin
      sck = 1'b0;
      rxd = 1'b0;
      busy = 1'b0;
      cnt = 0;
      frames = 0;
      got0 = 24'h0;
      got1 = 24'h0;
   end

   // clock stands low while run is low, 80 ns period while run is high
   always #40 sck = run ? ~sck : 1'b0;

   // data moves only on rises so it never races the sampling fall
   always @(posedge sck) begin
      rxd = busy ? curWord[23 - cnt] : curWord[23];
   end

   always @(negedge sck) begin
      if (busy || fsync) begin
         shiftReg = {shiftReg[22:0], txd};
         cnt = cnt + 1;
         busy = 1'b1;
         if (cnt == 24) begin
            if (frames[0]) got1 = shiftReg;
            else got0 = shiftReg;
            frames = frames + 1;
            busy = 1'b0;
            cnt = 0;
         end
      end
   end
endmodule : ssp_codec_model

/* File: test/sync_serial_port_pins_bench.sv */
// sync_serial_port_pins_bench.sv: self-checking bench of ssp_port
// assumes the codec model sources the bit clock in the frame test
`timescale 1ns/10ps
module sync_serial_port_pins_bench;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [5:0]  funcSel = 6'h0;
   logic [5:0]  gpioDir = 6'h0;
   logic [5:0]  gpioOut = 6'h0;
   logic        asyncMode = 1'b0;
   logic        clkOutMode = 1'b0;
   logic        fsOutMode = 1'b0;
   logic [1:0]  flagOut = 2'h0;
   logic        txValid = 1'b0;
   logic [23:0] txWord = 24'h0;
   logic        rxReady = 1'b0;
   logic [5:0]  extPins = 6'h0;
   logic        run = 1'b0;
   logic        txReady, rxValid, sckLine, rxdLine;
   logic [23:0] rxWord, got0, got1;
   logic [5:0]  gpioIn, pinOut, pinOen_n, pinWire;
   logic [1:0]  flagIn;
   wire  [5:0]  pinIn;
   int          frames;
   int          fail_count = 0;
   int          total_checks = 0;

   always #5 core_clk = ~core_clk;

   // ----------------------------------------------------------
   // pins: a driven pin shows the port, a released one the bench
   // ----------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pinWire[i] = pinOen_n[i] ? extPins[i] : pinOut[i];
      end
   end
   assign pinIn = {pinWire[5], rxdLine, sckLine, pinWire[2:0]};

   ssp_port #(.WORD_BITS(24), .CLK_DIV(4)) u_ssp_port (
      .core_clk(core_clk), .arst_n(arst_n), .funcSel(funcSel),
      .gpioDir(gpioDir), .gpioOut(gpioOut), .asyncMode(asyncMode),
      .clkOutMode(clkOutMode), .fsOutMode(fsOutMode),
      .flagOut(flagOut), .txValid(txValid), .txReady(txReady),
      .txWord(txWord), .rxValid(rxValid), .rxReady(rxReady),
      .rxWord(rxWord), .gpioIn(gpioIn), .flagIn(flagIn),
      .pinIn(pinIn), .pinOut(pinOut), .pinOen_n(pinOen_n));

   ssp_codec_model u_ssp_codec_model (
      .run(run), .word0(24'hC3_0F96), .word1(24'h1E_7A2D),
      .fsync(pinWire[2]), .txd(pinWire[5]), .sck(sckLine),
      .rxd(rxdLine), .got0(got0), .got1(got1), .frames(frames));

   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic check(input string name, input logic [23:0] exp,
                        input logic [23:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   // holds the word up until the accepting edge; caller lowers valid
   task automatic sendWord(input logic [23:0] w);
      txValid <= 1'b1;
      txWord  <= w;
      for (int i = 0; i < 1000; i++) begin
         @(posedge core_clk);
         if (txReady === 1'b1) break;
      end
      check("tx accept", 24'h1, 24'(txReady));
   endtask : sendWord

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic test_reset;
      cyc(6);
      check("reset oen", 24'h3F, 24'(pinOen_n));
      arst_n <= 1'b1;
      cyc(2);
      check("oen after reset", 24'h3F, 24'(pinOen_n));
      check("rx valid after reset", 24'h0, 24'(rxValid));
   endtask : test_reset

   task automatic test_gpio;
      gpioDir <= 6'h3F;
      gpioOut <= 6'h2A;
      cyc(3);
      check("gpio out", 24'h2A, 24'(pinOut));
      check("gpio oen", 24'h0, 24'(pinOen_n));
      gpioDir <= 6'h0;
      extPins <= 6'h25;
      cyc(6);
      check("gpio oen off", 24'h3F, 24'(pinOen_n));
      check("gpio in", 24'h25, 24'(gpioIn & 6'h27));
   endtask : test_gpio

   task automatic test_flags;
      funcSel <= 6'h03;
      gpioDir <= 6'h03;
      for (int v = 0; v < 4; v++) begin
         flagOut <= 2'(v);
         cyc(3);
         check("flag pins", 24'(v), 24'(pinOut[1:0]));
      end
      cyc(5);
      check("flag in", 24'h3, 24'(flagIn));
   endtask : test_flags

   task automatic test_async;
      int   toggles;
      logic last;
      asyncMode  <= 1'b1;
      funcSel    <= 6'h07;
      clkOutMode <= 1'b1;
      fsOutMode  <= 1'b1;
      cyc(3);
      check("aux drive", 24'h0, 24'(pinOen_n[2:0]));
      toggles = 0;
      last = pinOut[0];
      repeat (40) begin
         @(posedge core_clk);
         if (pinOut[0] !== last) toggles++;
         last = pinOut[0];
      end
      check("aux0 clock", 24'h1, 24'(toggles > 4));
      clkOutMode <= 1'b0;
      fsOutMode  <= 1'b0;
      cyc(3);
      check("aux release", 24'h7, 24'(pinOen_n[2:0]));
   endtask : test_async

   // two frames back to back while the receiver stalls
   task automatic test_frames;
      asyncMode <= 1'b0;
      fsOutMode <= 1'b1;
      funcSel   <= 6'h3C;
      run       <= 1'b1;
      sendWord(24'hA5_C3E1);
      sendWord(24'h80_0001);
      txValid <= 1'b0;
      for (int i = 0; i < 2000 && frames < 2; i++) @(posedge core_clk);
      cyc(20);
      check("frames", 24'h2, 24'(frames));
      check("tx word 0", 24'hA5_C3E1, got0);
      check("tx word 1", 24'h80_0001, got1);
      check("rx valid", 24'h1, 24'(rxValid));
      check("rx word 0", 24'hC3_0F96, rxWord);
      rxReady <= 1'b1;
      @(posedge core_clk);
      rxReady <= 1'b0;
      cyc(1);
      check("rx valid 1", 24'h1, 24'(rxValid));
      check("rx word 1", 24'h1E_7A2D, rxWord);
      rxReady <= 1'b1;
      @(posedge core_clk);
      rxReady <= 1'b0;
      run     <= 1'b0;
      cyc(1);
      check("rx drained", 24'h0, 24'(rxValid));
   endtask : test_frames

   // ----------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------
   initial begin
      test_reset();
      test_gpio();
      test_flags();
      test_async();
      test_frames();
      results();
   end

   // frames take about 192 cycles each; this leaves wide margin
   initial begin
      #500_000;
      fail_count++;
      results();
   end
endmodule : sync_serial_port_pins_bench
